// File: hdl/pscr_defines.svh
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH
// cache geometry: eight counter slots of 18 bits each
`define PSCR_CACHE_BITS 144
`define PSCR_SLOT_BITS 18
`define PSCR_SLOT_CNT 8
// parameter field layout inside a slot
`define PSCR_OFF_HIGH 5'h00
`define PSCR_OFF_LOW 5'h08
`define PSCR_OFF_BYP 5'h10
`define PSCR_OFF_MODE 5'h11
`define PSCR_OFF_NOM 5'h00
`define PSCR_OFF_CPLF 5'h00
// parameter field widths
`define PSCR_W_HIGH 4'h8
`define PSCR_W_LOW 4'h8
`define PSCR_W_BYP 4'h1
`define PSCR_W_MODE 4'h1
`define PSCR_W_NOM 4'h9
`define PSCR_W_CPLF 4'h2
// timing: rom latency, synchroniser depth, scan clock half period, loop reset length
`define PSCR_ROM_LAT 2
`define PSCR_SYNC_STG 2
`define PSCR_PIPE_DEP 4
`define PSCR_SCK_HALF 4'h4
`define PSCR_ARST_CYC 4'h4
// variant: 1 pulses scan-write on an unchanged cache, 0 rescans the chain
`define PSCR_BURST_MODE 1'b0
`endif

// File: hdl/pscr_pkg.sv
package pscr_pkg;
  typedef enum logic [3:0] {
    PSCR_IDLE, PSCR_READ, PSCR_WRITE, PSCR_SCAN, PSCR_UPDATE,
    PSCR_WDONE, PSCR_ARST, PSCR_ROM, PSCR_DRAIN
  } pscr_state_t;
  // one rom bit in flight: valid flag and target cache index
  typedef struct packed {
    logic vld;
    logic [7:0] idx;
  } pscr_rom_slot_t;
  // one-cycle requests from user logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic rcfg;
    logic rom_load;
    logic rom_restart;
  } pscr_req_t;
endpackage

// File: hdl/pscr_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for inputs from outside the clock domain
module pscr_sync #(
  parameter int W = 1
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pscr_sync_t;
  pscr_sync_t st_r, st_nxt;
  // first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule

// File: hdl/pscr_sclk.sv
`timescale 1ns/100ps
`include "pscr_defines.svh"
// free-running scan clock divider with edge strobes
module pscr_sclk (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  output logic sck,
  output logic sck_rise,
  output logic sck_fall
);
  typedef struct packed {
    logic [3:0] cnt;
    logic sck;
    logic rise;
    logic fall;
  } pscr_sclk_t;
  pscr_sclk_t st_r, st_nxt;
  // toggle every half period, flag the edge in the same cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (st_r.cnt == `PSCR_SCK_HALF - 4'h1) begin
      st_nxt.cnt = 4'h0;
      st_nxt.sck = ~st_r.sck;
      st_nxt.rise = ~st_r.sck;
      st_nxt.fall = st_r.sck;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end
  assign sck = st_r.sck;
  assign sck_rise = st_r.rise;
  assign sck_fall = st_r.fall;
endmodule

// File: hdl/pscr_ctrl.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "pscr_defines.svh"
module pscr_ctrl (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic READ_REQ,
  input wire logic WRITE_REQ,
  input wire logic RECONFIG_REQ,
  input wire logic ROM_LOAD_REQ,
  input wire logic ROM_RESTART,
  input wire logic [3:0] CNT_SEL,
  input wire logic [2:0] PARAM_SEL,
  input wire logic [8:0] WR_DATA,
  input wire logic LOOP_RESET_IN,
  input wire logic SCAN_DONE,
  input wire logic SCAN_DATA_RET,
  input wire logic ROM_BIT,
  output logic BUSY,
  output logic [8:0] RD_DATA,
  output logic LOOP_RESET,
  output logic CFG_UPDATE,
  output logic SCAN_CLK,
  output logic SCAN_CLK_EN,
  output logic SCAN_DATA,
  output logic SCAN_CLR,
  output logic SCAN_READ,
  output logic SCAN_WRITE,
  output logic [7:0] ROM_ADDR,
  output logic ROM_RD_EN
);
  typedef struct packed {
    pscr_pkg::pscr_state_t st;
    logic busy;
    logic [8:0] dout;
    logic [`PSCR_CACHE_BITS-1:0] cache;
    logic [8:0] wdat;
    logic [3:0] tsel;
    logic [2:0] psel;
    logic dirty;
    logic [7:0] bitcnt;
    logic ena;
    logic sdata;
    logic cfgupd;
    logic swrite;
    logic arst;
    logic [3:0] acnt;
    logic rom_ena;
    logic [7:0] rom_addr;
    pscr_pkg::pscr_rom_slot_t [`PSCR_PIPE_DEP-1:0] pipe;
    logic sd_prev;
    logic lrst;
  } pscr_ctrl_t;

  pscr_ctrl_t st_r, st_nxt;
  pscr_pkg::pscr_req_t req;
  logic [2:0] pin_s;
  logic sck, sck_rise, sck_fall;

  // field width of a parameter, zero for an illegal selection
  function automatic logic [3:0] fld_w(input logic [3:0] t, input logic [2:0] p);
    logic [3:0] w;
    w = 4'h0;
    if (t < 4'h8) begin
      unique case (p)
        3'h0: w = (t == 4'h0 || t == 4'h1) ? `PSCR_W_HIGH : `PSCR_W_HIGH;
        3'h1: w = `PSCR_W_LOW;
        3'h2: w = `PSCR_W_CPLF;
        3'h4: w = `PSCR_W_BYP;
        3'h5: w = `PSCR_W_MODE;
        3'h7: w = `PSCR_W_NOM;
        default: w = 4'h0;
      endcase
    end
    return w;
  endfunction

  // bit position of a parameter inside the cache
  function automatic logic [7:0] fld_off(input logic [3:0] t, input logic [2:0] p);
    logic [4:0] o;
    o = 5'h00;
    unique case (p)
      3'h0: o = `PSCR_OFF_HIGH;
      3'h1: o = `PSCR_OFF_LOW;
      3'h2: o = `PSCR_OFF_CPLF;
      3'h4: o = `PSCR_OFF_BYP;
      3'h5: o = `PSCR_OFF_MODE;
      3'h7: o = `PSCR_OFF_NOM;
      default: o = 5'h00;
    endcase
    return 8'(t[2:0] * `PSCR_SLOT_BITS) + {3'h0, o};
  endfunction

  // pins from the loop and the rom cross into this domain
  pscr_sync #(.W(3)) u_sync (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .CE(CE),
    .d({SCAN_DONE, SCAN_DATA_RET, ROM_BIT}),
    .q(pin_s)
  );

  pscr_sclk u_sclk (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .CE(CE),
    .sck(sck),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall)
  );

  // bundle the request strobes
  always_comb begin
    req.rd = READ_REQ;
    req.wr = WRITE_REQ;
    req.rcfg = RECONFIG_REQ;
    req.rom_load = ROM_LOAD_REQ;
    req.rom_restart = ROM_RESTART;
  end

  // controller next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.cfgupd = st_r.cfgupd;
    st_nxt.swrite = 1'b0;
    st_nxt.sd_prev = pin_s[2];
    // rom bits travel down the pipe and land at their cache index
    st_nxt.pipe[0].vld = st_r.rom_ena;
    st_nxt.pipe[0].idx = st_r.rom_ena ? st_r.rom_addr : 8'h00; // empty slots read as zero for the drain test
    for (int i = 1; i < `PSCR_PIPE_DEP; i++) begin
      st_nxt.pipe[i] = st_r.pipe[i-1];
    end
    if (st_r.pipe[`PSCR_PIPE_DEP-1].vld) begin
      st_nxt.cache[st_r.pipe[`PSCR_PIPE_DEP-1].idx] = pin_s[0];
    end
    if (req.rom_restart) begin
      st_nxt.rom_addr = 8'h00;
    end
    unique case (st_r.st)
      pscr_pkg::PSCR_IDLE: begin
        st_nxt.tsel = CNT_SEL;
        st_nxt.psel = PARAM_SEL;
        st_nxt.wdat = WR_DATA;
        if (req.rd) begin
          st_nxt.st = pscr_pkg::PSCR_READ;
          st_nxt.busy = 1'b1;
        end else if (req.wr) begin
          st_nxt.st = pscr_pkg::PSCR_WRITE;
          st_nxt.busy = 1'b1;
        end else if (req.rcfg) begin
          st_nxt.busy = 1'b1;
          st_nxt.dirty = 1'b0;
          if (`PSCR_BURST_MODE && !st_r.dirty) begin
            st_nxt.swrite = 1'b1;
            st_nxt.st = pscr_pkg::PSCR_WDONE;
          end else begin
            st_nxt.st = pscr_pkg::PSCR_SCAN;
            st_nxt.bitcnt = 8'h00;
          end
        end else if (req.rom_load) begin
          st_nxt.st = pscr_pkg::PSCR_ROM;
          st_nxt.busy = 1'b1;
          st_nxt.rom_ena = 1'b1;
          st_nxt.rom_addr = 8'h00;
          st_nxt.dirty = 1'b1;
        end
      end
      pscr_pkg::PSCR_READ: begin
        // selected field, upper bits zero
        st_nxt.dout = 9'((st_r.cache >> fld_off(st_r.tsel, st_r.psel))
          & ((`PSCR_CACHE_BITS'(1) << fld_w(st_r.tsel, st_r.psel)) - `PSCR_CACHE_BITS'(1)));
        st_nxt.busy = 1'b0;
        st_nxt.st = pscr_pkg::PSCR_IDLE;
      end
      pscr_pkg::PSCR_WRITE: begin
        // latched write data only, the port is not looked at here
        for (int i = 0; i < 9; i++) begin
          if (4'(i) < fld_w(st_r.tsel, st_r.psel)) begin
            st_nxt.cache[fld_off(st_r.tsel, st_r.psel) + 8'(i)] = st_r.wdat[i];
          end
        end
        st_nxt.dirty = 1'b1;
        st_nxt.busy = 1'b0;
        st_nxt.st = pscr_pkg::PSCR_IDLE;
      end
      pscr_pkg::PSCR_SCAN: begin
        // data changes on scan-clock falls, the loop samples on rises
        if (sck_fall) begin
          if (!st_r.ena) begin
            st_nxt.ena = 1'b1;
            st_nxt.sdata = st_r.cache[0];
          end else if (st_r.bitcnt == 8'(`PSCR_CACHE_BITS)) begin
            st_nxt.ena = 1'b0;
            st_nxt.cfgupd = 1'b1;
            st_nxt.st = pscr_pkg::PSCR_UPDATE;
          end else begin
            st_nxt.sdata = st_r.cache[st_r.bitcnt];
          end
        end
        if (sck_rise && st_r.ena) begin
          st_nxt.bitcnt = st_r.bitcnt + 8'h01;
        end
      end
      pscr_pkg::PSCR_UPDATE: begin
        // a fast pulsing loop can finish before the update strobe ends
        if (pin_s[2] && !st_r.sd_prev) begin
          st_nxt.cfgupd = 1'b0;
          st_nxt.st = pscr_pkg::PSCR_ARST;
          st_nxt.arst = 1'b1;
          st_nxt.acnt = 4'h0;
        end else if (sck_fall) begin
          st_nxt.cfgupd = 1'b0;
          st_nxt.st = pscr_pkg::PSCR_WDONE;
        end
      end
      pscr_pkg::PSCR_WDONE: begin
        // a rise of done marks completion for either loop style
        if (pin_s[2] && !st_r.sd_prev) begin
          st_nxt.st = pscr_pkg::PSCR_ARST;
          st_nxt.arst = 1'b1;
          st_nxt.acnt = 4'h0;
        end
      end
      pscr_pkg::PSCR_ARST: begin
        if (st_r.acnt == `PSCR_ARST_CYC - 4'h1) begin
          st_nxt.arst = 1'b0;
          st_nxt.busy = 1'b0;
          st_nxt.st = pscr_pkg::PSCR_IDLE;
        end else begin
          st_nxt.acnt = st_r.acnt + 4'h1;
        end
      end
      pscr_pkg::PSCR_ROM: begin
        // each address stands one cycle; restart gaps enable for a cycle
        if (req.rom_restart) begin
          st_nxt.rom_ena = 1'b0;
        end else if (!st_r.rom_ena) begin
          st_nxt.rom_ena = 1'b1;
        end else if (st_r.rom_addr == 8'(`PSCR_CACHE_BITS - 1)) begin
          st_nxt.rom_ena = 1'b0;
          st_nxt.st = pscr_pkg::PSCR_DRAIN;
        end else begin
          st_nxt.rom_addr = st_r.rom_addr + 8'h01;
        end
      end
      pscr_pkg::PSCR_DRAIN: begin
        if (req.rom_restart) begin
          st_nxt.st = pscr_pkg::PSCR_ROM;
        end else if (st_r.pipe == '0) begin
          st_nxt.busy = 1'b0;
          st_nxt.st = pscr_pkg::PSCR_IDLE;
        end
      end
      default: begin
        st_nxt.st = pscr_pkg::PSCR_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
    // loop reset follows the user input and the reconfig reset state
    st_nxt.lrst = LOOP_RESET_IN | st_nxt.arst;
  end

  // state register; synchronous reset on RST_B low, held while CE is low
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign BUSY = st_r.busy;
  assign RD_DATA = st_r.dout;
  assign LOOP_RESET = st_r.lrst;
  assign CFG_UPDATE = st_r.cfgupd;
  assign SCAN_CLK = sck;
  assign SCAN_CLK_EN = st_r.ena;
  assign SCAN_DATA = st_r.sdata;
  assign SCAN_CLR = st_r.arst;
  assign SCAN_READ = st_r.swrite;
  assign SCAN_WRITE = st_r.swrite;
  assign ROM_ADDR = st_r.rom_addr;
  assign ROM_RD_EN = st_r.rom_ena;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  logic idle_req;
  assign idle_req = CE && st_r.st == pscr_pkg::PSCR_IDLE && (READ_REQ || WRITE_REQ || RECONFIG_REQ);

  AST_BUSY_NEXT: assert property (idle_req && !BUSY |=> BUSY)
    else $error("busy did not rise after request");
  AST_READ_TWO: assert property (CE && st_r.st == pscr_pkg::PSCR_IDLE && READ_REQ ##1 CE |=> !BUSY)
    else $error("read busy did not fall after one cycle");
  AST_READ_W: assert property (CE && st_r.st == pscr_pkg::PSCR_READ |=> RD_DATA[8] == 1'b0
    || fld_w($past(st_r.tsel), $past(st_r.psel)) == 4'h9)
    else $error("read data bit above width set");
  AST_WRITE_BUSY: assert property (st_r.st == pscr_pkg::PSCR_WRITE |-> BUSY)
    else $error("busy low during write");
  AST_CACHE_HOLD: assert property (CE && st_r.st inside {pscr_pkg::PSCR_SCAN, pscr_pkg::PSCR_UPDATE,
    pscr_pkg::PSCR_WDONE, pscr_pkg::PSCR_ARST} |=> $stable(st_r.cache))
    else $error("cache changed during reconfiguration");
  AST_LRST_IN: assert property (CE && LOOP_RESET_IN |=> LOOP_RESET)
    else $error("loop reset did not follow input");
  AST_CFG_AFTER: assert property ($rose(CFG_UPDATE) |-> !SCAN_CLK_EN && $past(SCAN_CLK_EN))
    else $error("config update not after last bit");
  AST_ARST_BUSY: assert property (st_r.arst |-> BUSY)
    else $error("busy low while loop reset from reconfig");
  AST_ROM_EN: assert property (CE && st_r.st == pscr_pkg::PSCR_IDLE && !READ_REQ && !WRITE_REQ
    && !RECONFIG_REQ && ROM_LOAD_REQ |=> ROM_RD_EN && ROM_ADDR == 8'h00)
    else $error("rom enable not raised after load");
  AST_ROM_STEP: assert property (CE && ROM_RD_EN && st_r.st == pscr_pkg::PSCR_ROM && !ROM_RESTART
    && ROM_ADDR != 8'(`PSCR_CACHE_BITS - 1) |=> ROM_ADDR == $past(ROM_ADDR) + 8'h01)
    else $error("rom address did not step");
  AST_ROM_RESTART: assert property (CE && ROM_RESTART && st_r.st == pscr_pkg::PSCR_ROM
    |=> !ROM_RD_EN && ROM_ADDR == 8'h00)
    else $error("rom restart not honoured");
  AST_RESET_IDLE: assert property ($rose(RST_B) |-> !BUSY && !SCAN_CLK_EN && ROM_ADDR == 8'h00)
    else $error("not idle after reset");

  COV_READ: cover property (st_r.st == pscr_pkg::PSCR_READ ##1 !BUSY);
  COV_RECONFIG: cover property ($fell(st_r.arst) && st_r.st == pscr_pkg::PSCR_IDLE);
  COV_ROM: cover property (st_r.st == pscr_pkg::PSCR_DRAIN ##1 st_r.st == pscr_pkg::PSCR_IDLE);
endmodule

// File: sim/pscr_loop_model.sv
`timescale 1ns/100ps
// loop scan chain and serial rom as seen from the controller
module pscr_loop_model (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic pulse_style,
  input wire logic [7:0] dly,
  input wire logic SCAN_CLK,
  input wire logic SCAN_CLK_EN,
  input wire logic SCAN_DATA,
  input wire logic CFG_UPDATE,
  input wire logic [7:0] ROM_ADDR,
  input wire logic ROM_RD_EN,
  output logic SCAN_DONE,
  output logic SCAN_DATA_RET,
  output logic ROM_BIT
);
  logic [143:0] got;
  int nbits = 0;
  int upd_n = 0;
  int ups = 0;
  logic en_q = 1'b0;
  logic upd_q = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [7:0] a1, a2;
  logic e1 = 1'b0;
  logic e2 = 1'b0;
  logic tgl = 1'b0;
  // chain takes a bit on each scan clock rise while enabled, first bit restarts it
  always @(posedge SCAN_CLK) begin
    en_q <= SCAN_CLK_EN;
    if (SCAN_CLK_EN) begin
      got[en_q ? nbits : 0] <= SCAN_DATA;
      nbits <= en_q ? nbits + 1 : 1;
    end
  end
  // done drops on update then returns, or pulses two cycles in the older style
  always @(posedge CLK_SYS) begin
    upd_q <= CFG_UPDATE;
    tgl <= ~tgl;
    {a2, a1} <= {a1, ROM_ADDR};
    {e2, e1} <= {e1, ROM_RD_EN};
    if (!RST_B) begin
      cnt <= 8'h00;
      SCAN_DONE <= ~pulse_style;
    end else if (CFG_UPDATE && !upd_q) begin
      upd_n <= nbits;
      ups <= ups + 1;
      cnt <= dly + 8'h03;
      SCAN_DONE <= 1'b0;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      SCAN_DONE <= pulse_style ? (cnt == 8'h03 || cnt == 8'h02) : (cnt == 8'h01);
    end else begin
      SCAN_DONE <= ~pulse_style;
    end
  end
  // rom answers two cycles late; a changing pattern when not valid
  assign ROM_BIT = e2 ? ^(a2 & 8'h5B) : tgl;
  assign SCAN_DATA_RET = tgl;
endmodule

// File: sim/pscr_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t %s", $time, m); end end
module pscr_ctrl_tb;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic CE = 1'b1;
  logic READ_REQ = 1'b0, WRITE_REQ = 1'b0, RECONFIG_REQ = 1'b0, ROM_LOAD_REQ = 1'b0, ROM_RESTART = 1'b0;
  logic LOOP_RESET_IN = 1'b0;
  logic [3:0] CNT_SEL = 4'h0;
  logic [2:0] PARAM_SEL = 3'h0;
  logic [8:0] WR_DATA = 9'h000;
  logic SCAN_DONE, SCAN_DATA_RET, ROM_BIT, BUSY, LOOP_RESET, CFG_UPDATE, SCAN_CLK, SCAN_CLK_EN;
  logic SCAN_DATA, SCAN_WRITE, ROM_RD_EN, SCAN_CLR, SCAN_READ;
  logic [8:0] RD_DATA;
  logic [7:0] ROM_ADDR;
  logic style = 1'b0;
  logic [7:0] dly = 8'h14;
  logic [143:0] exp_c = 'x;
  int mismatches = 0;
  int checks_done = 0;

  always #4 CLK_SYS = ~CLK_SYS;

  pscr_ctrl pscr_ctrl_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .READ_REQ(READ_REQ),
    .WRITE_REQ(WRITE_REQ), .RECONFIG_REQ(RECONFIG_REQ), .ROM_LOAD_REQ(ROM_LOAD_REQ),
    .ROM_RESTART(ROM_RESTART), .CNT_SEL(CNT_SEL), .PARAM_SEL(PARAM_SEL), .WR_DATA(WR_DATA),
    .LOOP_RESET_IN(LOOP_RESET_IN), .SCAN_DONE(SCAN_DONE), .SCAN_DATA_RET(SCAN_DATA_RET),
    .ROM_BIT(ROM_BIT), .BUSY(BUSY), .RD_DATA(RD_DATA), .LOOP_RESET(LOOP_RESET),
    .CFG_UPDATE(CFG_UPDATE), .SCAN_CLK(SCAN_CLK), .SCAN_CLK_EN(SCAN_CLK_EN), .SCAN_DATA(SCAN_DATA),
    .SCAN_CLR(SCAN_CLR), .SCAN_READ(SCAN_READ), .SCAN_WRITE(SCAN_WRITE),
    .ROM_ADDR(ROM_ADDR), .ROM_RD_EN(ROM_RD_EN));

  pscr_loop_model pscr_loop_model_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pulse_style(style), .dly(dly),
    .SCAN_CLK(SCAN_CLK), .SCAN_CLK_EN(SCAN_CLK_EN), .SCAN_DATA(SCAN_DATA), .CFG_UPDATE(CFG_UPDATE),
    .ROM_ADDR(ROM_ADDR), .ROM_RD_EN(ROM_RD_EN), .SCAN_DONE(SCAN_DONE), .SCAN_DATA_RET(SCAN_DATA_RET),
    .ROM_BIT(ROM_BIT));

  // field offset and width inside a slot
  function automatic int foff(input logic [2:0] p);
    return (p == 3'h1) ? 8 : (p == 3'h4) ? 16 : (p == 3'h5) ? 17 : 0;
  endfunction
  function automatic int fw(input logic [2:0] p);
    return (p < 3'h2) ? 8 : (p == 3'h2) ? 2 : (p < 3'h7) ? 1 : 9;
  endfunction
  function automatic logic [8:0] fld(input int c, input logic [2:0] p);
    fld = 9'h000;
    for (int i = 0; i < fw(p); i++) fld[i] = exp_c[c * 18 + foff(p) + i];
  endfunction

  task automatic summarize;
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // bounded wait for busy to fall
  task automatic wait_idle(input int n);
    for (int i = 0; i < n; i++) begin
      if (BUSY === 1'b0) return;
      @(posedge CLK_SYS);
      #1;
    end
    mismatches++;
    $display("[ERR] %0t busy stuck", $time);
    summarize();
  endtask

  // one-cycle read or write request, busy only from the next edge
  task automatic op(input logic [1:0] k, input logic [3:0] c, input logic [2:0] p, input logic [8:0] d);
    @(posedge CLK_SYS);
    READ_REQ <= k[0];
    WRITE_REQ <= k[1];
    CNT_SEL <= c;
    PARAM_SEL <= p;
    WR_DATA <= d;
    #1;
    `CHK(BUSY, 1'b0, "busy too early")
    @(posedge CLK_SYS);
    READ_REQ <= 1'b0;
    WRITE_REQ <= 1'b0;
    WR_DATA <= ~d;
    #1;
    `CHK(BUSY, 1'b1, "busy missing")
    wait_idle(4);
  endtask
  task automatic wr(input int c, input logic [2:0] p, input logic [8:0] d);
    op(2'h2, c[3:0], p, d);
    for (int i = 0; i < fw(p); i++) exp_c[c * 18 + foff(p) + i] = d[i];
  endtask
  task automatic rd(input int c, input logic [2:0] p);
    op(2'h1, c[3:0], p, 9'h1FF);
    `CHK(RD_DATA, fld(c, p), "read data")
  endtask

  task automatic t_reset;
    `CHK({BUSY, SCAN_CLK_EN, ROM_RD_EN, LOOP_RESET}, 4'h0, "reset outputs")
    `CHK(ROM_ADDR, 8'h00, "reset rom address")
  endtask

  task automatic t_param;
    wr(2, 3'h0, 9'h1A5);
    wr(2, 3'h1, 9'h03C);
    wr(2, 3'h4, 9'h1FF);
    wr(2, 3'h5, 9'h000);
    wr(7, 3'h2, 9'h0F6);
    for (int p = 0; p < 8; p++) if (p != 3 && p != 6) rd(2, p[2:0]);
    rd(7, 3'h2);
    op(2'h1, 4'h9, 3'h0, 9'h000);
    `CHK(RD_DATA, 9'h000, "illegal counter read")
  endtask

  task automatic t_rom;
    @(posedge CLK_SYS);
    ROM_LOAD_REQ <= 1'b1;
    @(posedge CLK_SYS);
    ROM_LOAD_REQ <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      #1;
      `CHK({BUSY, ROM_RD_EN, ROM_ADDR}, {2'h3, k[7:0]}, "rom step")
      @(posedge CLK_SYS);
    end
    ROM_RESTART <= 1'b1;
    @(posedge CLK_SYS);
    ROM_RESTART <= 1'b0;
    #1;
    `CHK({ROM_RD_EN, ROM_ADDR}, 9'h000, "restart gap")
    for (int k = 0; k < 145; k++) begin
      @(posedge CLK_SYS);
      #1;
      if (k < 144) `CHK({ROM_RD_EN, ROM_ADDR}, {1'b1, k[7:0]}, "rom restep")
      else `CHK(ROM_RD_EN, 1'b0, "rom end")
    end
    wait_idle(20);
    for (int a = 0; a < 144; a++) exp_c[a] = ^(a[7:0] & 8'h5B);
    for (int c = 0; c < 8; c++) begin
      rd(c, 3'h0);
      rd(c, 3'h1);
      rd(c, 3'h4);
      rd(c, 3'h5);
    end
  endtask

  // full reconfiguration against the loop model
  task automatic t_rcfg(input logic s, input logic [7:0] dl);
    int n0;
    logic lr;
    n0 = pscr_loop_model_i.ups;
    lr = 1'b0;
    @(posedge CLK_SYS);
    style <= s;
    dly <= dl;
    @(posedge CLK_SYS);
    RECONFIG_REQ <= 1'b1;
    @(posedge CLK_SYS);
    RECONFIG_REQ <= 1'b0;
    #1;
    `CHK(BUSY, 1'b1, "reconfig busy")
    for (int i = 0; i < 3000; i++) begin
      lr = lr | LOOP_RESET;
      `CHK({SCAN_READ, SCAN_WRITE}, 2'h0, "scan write pulse")
      `CHK(SCAN_CLR, LOOP_RESET, "scan clear apart from loop reset")
      @(posedge CLK_SYS);
      #1;
      if (BUSY === 1'b0) break;
    end
    wait_idle(1);
    `CHK({lr, LOOP_RESET}, 2'h2, "loop reset around busy")
    `CHK(pscr_loop_model_i.got, exp_c, "scanned chain")
    `CHK(pscr_loop_model_i.upd_n, 144, "bits before update")
    `CHK(pscr_loop_model_i.ups, n0 + 1, "one update")
    rd(3, 3'h0);
  endtask

  task automatic t_lrst;
    @(posedge CLK_SYS);
    LOOP_RESET_IN <= 1'b1;
    CE <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    CE <= 1'b1;
    #1;
    `CHK(LOOP_RESET, 1'b0, "loop reset moved with enable low")
    @(posedge CLK_SYS);
    #1;
    `CHK(LOOP_RESET, 1'b1, "user loop reset")
    @(posedge CLK_SYS);
    LOOP_RESET_IN <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    `CHK(LOOP_RESET, 1'b0, "loop reset release")
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    #1;
    t_reset();
    t_param();
    t_rom();
    wr(3, 3'h0, 9'h05A);
    t_rcfg(1'b0, 8'h14);
    t_rcfg(1'b1, 8'h03);
    t_lrst();
    summarize();
  end
endmodule
